// ---- logic/dtcm_menu.sv ----
// Purpose: keypad configuration sequencer with AHB-Lite register view
// Assumes: keypad events are single-cycle strobes synchronous to hclk
// Notes:   all outputs are flops; zero-wait-state bus slave
//
// The register offsets and the AHB-Lite register port were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none

module dtcm_menu
  import dtcm_pkg::*;
(
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [7:0]  haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic [31:0]      hrdata,
  input  wire logic        diag_ok,
  input  wire logic        key_stb,
  input  wire logic [1:0]  key_kind,
  input  wire logic [3:0]  key_code,
  input  wire logic        test_start,
  input  wire logic        test_error,
  input  wire logic        test_pass_done,
  output logic [1:0]       active_row_q,
  output logic [3:0]       param_sel_q,
  output logic [11:0]      disp_value_q,
  output logic             disp_blink_q,
  output logic             disp_na_q,
  output logic [3:0]       led_bright_q,
  output logic [3:0]       head_select_code_q,
  output logic [7:0]       tracks_per_surface_q,
  output logic [7:0]       table_idx_q,
  output logic [11:0]      step_period_nominal_q,
  output logic [11:0]      step_period_start_q,
  output logic [11:0]      step_period_end_q,
  output logic [7:0]       drive_sel_q,
  output logic [7:0]       humidity_q,
  output logic [7:0]       mux_ports_q,
  output logic             mux_on_q,
  output logic [7:0]       uart_active_q,
  output logic [8:0]       pass_limit_q,
  output logic             test_run_q
);

  // ---------------------------------------------------------------
  // menu state
  // ---------------------------------------------------------------
  dtcm_state_t state_q;
  logic [11:0] edit_q;
  logic [3:0]  eflag_q;       // {single pass, halt, all tracks, one track}
  logic        one_trk_q;
  logic        all_trk_q;
  logic        halt_q;
  logic        spass_q;
  logic        opt_q;
  logic [7:0]  ustage_q;
  logic [8:0]  pass_cnt_q;

  logic k_col;
  logic k_ent;
  logic k_row;
  logic is_flag;
  logic commit;
  logic ok;
  logic [3:0] nxt;
  assign k_col   = key_stb && key_kind == DTCM_K_COL;
  assign k_ent   = key_stb && key_kind == DTCM_K_ENTER;
  assign k_row   = key_stb && key_kind == DTCM_K_ROW;
  assign is_flag = param_sel_q >= P_ONE && param_sel_q <= P_SPASS;
  assign commit  = state_q == ST_EDIT && (k_ent || k_row);

  // three bcd digits, not all zero: 0.1 to 99.9 ms
  function automatic logic bcd3_ok(input logic [11:0] v);
    bcd3_ok = v[11:8] <= DTCM_BCD_MAX && v[7:4] <= DTCM_BCD_MAX &&
              v[3:0] <= DTCM_BCD_MAX && v != 12'h000;
  endfunction

  // range check of the keyed value for the open parameter
  always_comb begin
    unique case (param_sel_q)
      P_HEADS:  ok = edit_q == 12'h001 || edit_q == 12'h002 ||
                     edit_q == 12'h004;
      P_TRACKS: ok = edit_q[11:8] == 4'h0 && edit_q[7:0] != 8'h00;
      P_TABLE:  ok = edit_q[11:8] == 4'h0 && edit_q[3:0] <= DTCM_BCD_MAX
                     && edit_q[7:0] <= DTCM_TABLE_MAX;
      P_NOM, P_MAX, P_MIN: ok = bcd3_ok(edit_q);
      P_HUM:    ok = opt_q && edit_q[11:8] == 4'h0 &&
                     edit_q[7:4] <= DTCM_BCD_MAX &&
                     edit_q[3:0] <= DTCM_BCD_MAX;
      P_DSEL, P_MUX: ok = edit_q[11:8] == 4'h0;
      default:  ok = 1'b0;
    endcase
  end

  // fixed auto-prompt chain; the flag screen wraps to the table index
  always_comb begin
    unique case (param_sel_q)
      P_TABLE:  nxt = P_HEADS;
      P_HEADS:  nxt = P_TRACKS;
      P_TRACKS: nxt = P_NOM;
      P_NOM:    nxt = P_MAX;
      P_MAX:    nxt = P_MIN;
      P_MIN:    nxt = P_DSEL;
      P_DSEL:   nxt = P_HUM;
      P_HUM:    nxt = P_MUX;
      P_MUX:    nxt = P_ONE;
      default:  nxt = P_TABLE;
    endcase
  end

  // ---------------------------------------------------------------
  // menu sequencer
  // ---------------------------------------------------------------
  // diagnostics gate the first editing screen
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_q      <= ST_DIAG;
      param_sel_q  <= P_TABLE;
      active_row_q <= DTCM_ROW_CFG;
    end else begin
      unique case (state_q)
        ST_DIAG: if (diag_ok) state_q <= ST_EDIT;
        ST_SELECT: if (k_row && key_code[1:0] != DTCM_ROW_CFG) begin
          state_q      <= ST_AWAY;
          active_row_q <= key_code[1:0];
        end else if (k_col && key_code != 4'h3 && key_code != 4'hF) begin
          state_q     <= ST_EDIT;
          param_sel_q <= key_code;
        end
        ST_EDIT: if (k_row) begin
          active_row_q <= key_code[1:0];
          state_q <= key_code[1:0] == DTCM_ROW_CFG ? ST_SELECT : ST_AWAY;
        end else if (k_ent) begin
          param_sel_q <= nxt;
        end
        ST_AWAY: if (k_row && key_code[1:0] == DTCM_ROW_CFG) begin
          state_q      <= ST_SELECT;
          active_row_q <= DTCM_ROW_CFG;
        end
      endcase
    end
  end

  // keyed digits shift into the entry buffer; reloaded on each open
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      edit_q  <= 12'h000;
      eflag_q <= 4'h0;
    end else if ((state_q == ST_DIAG && diag_ok) ||
                 (state_q == ST_EDIT && k_ent) ||
                 (state_q == ST_SELECT && k_col)) begin
      eflag_q <= {spass_q, halt_q, all_trk_q, one_trk_q};
      unique case (state_q == ST_DIAG ? P_TABLE :
                   state_q == ST_SELECT ? key_code : nxt)
        P_TABLE: edit_q <= {4'h0, table_idx_q};
        P_HEADS: edit_q <= {8'h00, head_select_code_q};
        P_TRACKS: edit_q <= {4'h0, tracks_per_surface_q};
        P_NOM:   edit_q <= step_period_nominal_q;
        P_MAX:   edit_q <= step_period_start_q;
        P_MIN:   edit_q <= step_period_end_q;
        P_DSEL:  edit_q <= {4'h0, drive_sel_q};
        P_HUM:   edit_q <= {4'h0, humidity_q};
        P_MUX:   edit_q <= {4'h0, mux_ports_q};
        default: edit_q <= 12'h000;
      endcase
    end else if (state_q == ST_EDIT && k_col) begin
      if (is_flag) begin
        unique case (key_code)
          P_ONE:   eflag_q[1:0] <= 2'b01;
          P_ALL:   eflag_q[1:0] <= 2'b10;
          P_HALT:  eflag_q[2]   <= ~eflag_q[2];
          P_SPASS: eflag_q[3]   <= ~eflag_q[3];
          default: eflag_q      <= eflag_q;
        endcase
      end else if (param_sel_q != P_HUM || opt_q) begin
        edit_q <= {edit_q[7:0], key_code};   // hex entry
      end
    end
  end

  // ---------------------------------------------------------------
  // stored parameters; a rejected entry leaves the old value
  // ---------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      head_select_code_q    <= DTCM_HEADS_RST;
      tracks_per_surface_q  <= DTCM_TRK_RST;
      table_idx_q           <= 8'h00;
      step_period_nominal_q <= DTCM_NOM_RST;
      step_period_start_q   <= DTCM_MAX_RST;
      step_period_end_q     <= DTCM_MIN_RST;
      drive_sel_q           <= DTCM_DSEL_RST;
      humidity_q            <= DTCM_HUM_DFLT;
      mux_ports_q           <= 8'h00;
      one_trk_q             <= 1'b0;
      all_trk_q             <= 1'b1;
      halt_q                <= 1'b0;
      spass_q               <= 1'b1;
    end else if (commit && is_flag) begin
      {spass_q, halt_q, all_trk_q, one_trk_q} <= eflag_q;
    end else if (commit && ok) begin
      unique case (param_sel_q)
        P_HEADS:  head_select_code_q    <= edit_q[3:0];
        P_TRACKS: tracks_per_surface_q  <= edit_q[7:0];
        P_TABLE:  table_idx_q           <= edit_q[7:0];
        P_NOM:    step_period_nominal_q <= edit_q;
        P_MAX:    step_period_start_q   <= edit_q;
        P_MIN:    step_period_end_q     <= edit_q;
        P_DSEL:   drive_sel_q           <= edit_q[7:0];
        P_HUM:    humidity_q            <= edit_q[7:0];
        P_MUX:    mux_ports_q           <= edit_q[7:0];
        default:  mux_ports_q           <= mux_ports_q;
      endcase
    end
  end

  // mux enable follows the stored byte: zero means off
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) mux_on_q <= 1'b0;
    else          mux_on_q <= mux_ports_q != 8'h00;
  end

  // serial settings latch only on enter at the load function
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) uart_active_q <= DTCM_UART_RST;
    else if (state_q == ST_EDIT && k_ent && param_sel_q == P_UART)
      uart_active_q <= ustage_q;
  end

  // ---------------------------------------------------------------
  // display drive
  // ---------------------------------------------------------------
  // blinking follows editing; humidity shows NA without the option
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      disp_value_q <= 12'h000;
      disp_blink_q <= 1'b0;
      disp_na_q    <= 1'b0;
      led_bright_q <= 4'h0;
    end else begin
      disp_blink_q <= state_q == ST_EDIT &&
                      !(param_sel_q == P_HUM && !opt_q);
      disp_value_q <= state_q == ST_EDIT ? edit_q : 12'h000;
      disp_na_q    <= state_q == ST_EDIT && param_sel_q == P_HUM &&
                      !opt_q;
      led_bright_q <= state_q == ST_EDIT && is_flag ? eflag_q :
                      {spass_q, halt_q, all_trk_q, one_trk_q};
    end
  end

  // ---------------------------------------------------------------
  // test run policy
  // ---------------------------------------------------------------
  // one-track repeats tracks_per_surface passes; all-tracks one sweep
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) pass_limit_q <= 9'h001;
    else if (one_trk_q)
      pass_limit_q <= {1'b0, tracks_per_surface_q};
    else pass_limit_q <= 9'h001;  // one pass out and back
  end

  // an error stops only under halt-on-error; a row key always stops
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      test_run_q <= 1'b0;
      pass_cnt_q <= 9'h000;
    end else if (test_start && !test_run_q) begin
      test_run_q <= 1'b1;
      pass_cnt_q <= 9'h000;
    end else if (test_run_q) begin
      if (k_row || (test_error && halt_q))
        test_run_q <= 1'b0;
      else if (test_pass_done) begin
        pass_cnt_q <= pass_cnt_q + 9'h001;
        if (spass_q && pass_cnt_q + 9'h001 >= pass_limit_q)
          test_run_q <= 1'b0;
      end
    end
  end

  // ---------------------------------------------------------------
  // AHB-Lite slave, zero wait states, always OKAY
  // ---------------------------------------------------------------
  logic       wr_pend_q;
  logic [7:0] wr_addr_q;
  logic       acc;
  assign acc = hsel && hready && htrans[1];
  // writes land in the data phase; hsize is a whole word only
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_q <= 1'b0;
      wr_addr_q <= 8'h00;
    end else if (hready) begin
      wr_pend_q <= acc && hwrite && hsize == 3'h2;
      wr_addr_q <= haddr;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      opt_q    <= 1'b0;
      ustage_q <= DTCM_UART_RST;
    end else if (wr_pend_q) begin
      if (wr_addr_q == DTCM_A_SYS)    opt_q    <= hwdata[DTCM_SYS_OPT];
      if (wr_addr_q == DTCM_A_USTAGE) ustage_q <= hwdata[7:0];
    end
  end

  // read data is captured at the address phase; unmapped reads zero
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata    <= 32'h0000_0000;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end else if (acc && !hwrite) begin
      unique case (haddr)
        DTCM_A_SYS:    hrdata <= {31'h0000_0000, opt_q};
        DTCM_A_USTAGE: hrdata <= {24'h00_0000, ustage_q};
        DTCM_A_UACT:   hrdata <= {24'h00_0000, uart_active_q};
        DTCM_A_SETUP0: hrdata <= {drive_sel_q, 4'h0, head_select_code_q,
                                  table_idx_q, tracks_per_surface_q};
        DTCM_A_SETUP1: hrdata <= {4'h0, step_period_start_q,
                                  4'h0, step_period_nominal_q};
        DTCM_A_SETUP2: hrdata <= {mux_ports_q, humidity_q,
                                  4'h0, step_period_end_q};
        DTCM_A_STATUS: hrdata <= {4'h0, edit_q, 3'h0, test_run_q,
                                  spass_q, halt_q, all_trk_q, one_trk_q,
                                  param_sel_q, 2'h0, state_q};
        default:       hrdata <= 32'h0000_0000;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  default clocking dtcm_cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  a_diag_opens_table: assert property (
    state_q == ST_DIAG && diag_ok |=>
      state_q == ST_EDIT && param_sel_q == P_TABLE)
    else $error("diagnostics did not open the table index");
  a_enter_advances: assert property (
    state_q == ST_EDIT && k_ent && param_sel_q == P_HEADS |=>
      state_q == ST_EDIT && param_sel_q == P_TRACKS)
    else $error("enter did not advance to the track count");
  a_row_key_leaves: assert property (
    state_q == ST_EDIT && k_row && key_code[1:0] != DTCM_ROW_CFG |=>
      state_q == ST_AWAY && active_row_q == $past(key_code[1:0]))
    else $error("row key did not transfer to its row");
  a_edit_blinks: assert property (
    (state_q == ST_EDIT && param_sel_q != P_HUM)[*2] |-> disp_blink_q)
    else $error("display not blinking while editing");
  a_heads_legal: assert property (
    head_select_code_q inside {4'h1, 4'h2, 4'h4})
    else $error("illegal head select code stored");
  a_tracks_range: assert property (
    tracks_per_surface_q != 8'h00)
    else $error("zero tracks stored");
  a_nominal_bcd: assert property (
    bcd3_ok(step_period_nominal_q) && bcd3_ok(step_period_end_q))
    else $error("step period out of range");
  a_table_range: assert property (
    table_idx_q <= DTCM_TABLE_MAX && table_idx_q[3:0] <= DTCM_BCD_MAX)
    else $error("test table index out of range");
  a_coverage_excl: assert property (
    !(one_trk_q && all_trk_q))
    else $error("both coverage modes on");
  a_halt_on_error: assert property (
    test_run_q && test_error && halt_q && !test_start |=> !test_run_q)
    else $error("test did not halt on error");
  a_uart_hold: assert property (
    !(state_q == ST_EDIT && k_ent && param_sel_q == P_UART) |=>
      $stable(uart_active_q))
    else $error("serial settings changed without load");
  a_reject_keeps: assert property (
    commit && !ok && param_sel_q == P_TRACKS |=>
      $stable(tracks_per_surface_q))
    else $error("rejected entry changed the track count");
  a_mux_off: assert property (
    mux_ports_q == 8'h00 [*2] |-> !mux_on_q)
    else $error("mux enabled with zero mask");

  c_full_chain: cover property (
    state_q == ST_EDIT && k_ent && param_sel_q == P_MUX);
  c_flag_toggle: cover property (
    state_q == ST_EDIT && k_col && key_code == P_HALT ##1 commit);
  c_uart_load: cover property (
    state_q == ST_EDIT && k_ent && param_sel_q == P_UART);
  c_reject: cover property (commit && !ok && !is_flag);

endmodule

`default_nettype wire

// ---- logic/dtcm_pkg.sv ----
// Purpose: constants and types for the drive tester configuration menu
// Assumes: one 20 MHz clock, AHB-Lite register access, keypad events

package dtcm_pkg;
  // ---------------------------------------------------------------
  // register map, byte addresses of aligned words
  // ---------------------------------------------------------------
  localparam logic [7:0] DTCM_A_SYS    = 8'h00;
  localparam logic [7:0] DTCM_A_USTAGE = 8'h04;
  localparam logic [7:0] DTCM_A_UACT   = 8'h08;
  localparam logic [7:0] DTCM_A_SETUP0 = 8'h0C;
  localparam logic [7:0] DTCM_A_SETUP1 = 8'h10;
  localparam logic [7:0] DTCM_A_SETUP2 = 8'h14;
  localparam logic [7:0] DTCM_A_STATUS = 8'h18;
  localparam int         DTCM_SYS_OPT  = 0;

  // ---------------------------------------------------------------
  // keypad event kinds, rows and parameter keys
  // ---------------------------------------------------------------
  localparam logic [1:0] DTCM_K_COL   = 2'h0;
  localparam logic [1:0] DTCM_K_ENTER = 2'h1;
  localparam logic [1:0] DTCM_K_ROW   = 2'h2;
  localparam logic [1:0] DTCM_ROW_CFG = 2'h1;
  localparam logic [3:0] P_HEADS = 4'h0;
  localparam logic [3:0] P_TRACKS = 4'h1;
  localparam logic [3:0] P_UART = 4'h2;
  localparam logic [3:0] P_TABLE = 4'h4;
  localparam logic [3:0] P_NOM = 4'h5;
  localparam logic [3:0] P_MAX = 4'h6;
  localparam logic [3:0] P_MIN = 4'h7;
  localparam logic [3:0] P_DSEL = 4'h8;
  localparam logic [3:0] P_HUM = 4'h9;
  localparam logic [3:0] P_MUX = 4'hA;
  localparam logic [3:0] P_ONE = 4'hB;
  localparam logic [3:0] P_ALL = 4'hC;
  localparam logic [3:0] P_HALT = 4'hD;
  localparam logic [3:0] P_SPASS = 4'hE;

  // ---------------------------------------------------------------
  // limits and reset values
  // ---------------------------------------------------------------
  localparam logic [7:0]  DTCM_TABLE_MAX = 8'h19;
  localparam logic [3:0]  DTCM_BCD_MAX   = 4'h9;
  localparam logic [7:0]  DTCM_HUM_DFLT  = 8'h50;
  localparam logic [3:0]  DTCM_HEADS_RST = 4'h2;
  localparam logic [7:0]  DTCM_TRK_RST   = 8'h50;
  localparam logic [11:0] DTCM_NOM_RST   = 12'h030;
  localparam logic [11:0] DTCM_MAX_RST   = 12'h060;
  localparam logic [11:0] DTCM_MIN_RST   = 12'h030;
  localparam logic [7:0]  DTCM_DSEL_RST  = 8'h01;
  localparam logic [7:0]  DTCM_UART_RST  = 8'h00;

  typedef enum logic [1:0] {
    ST_DIAG, ST_SELECT, ST_EDIT, ST_AWAY
  } dtcm_state_t;
endpackage

// ---- testbench/drive_tester_config_menu_tb_top.sv ----
// Purpose: self-checking bench for the configuration menu
// Assumes: zero-wait bus slave, keys driven through the operator model
// Notes:   each key step waits one extra edge for the display flops
`timescale 1ns/1ps
`default_nettype none

module drive_tester_config_menu_tb_top
  import dtcm_pkg::*;
;
  localparam logic [1:0] C = DTCM_K_COL;
  localparam logic [1:0] E = DTCM_K_ENTER;
  localparam logic [1:0] R = DTCM_K_ROW;
  logic hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, hreadyout, hready;
  logic diag_ok = 0, test_start = 0, test_error = 0, key_stb, mux_on_q;
  logic test_pass_done = 0, hresp;
  logic disp_blink_q, disp_na_q, test_run_q;
  logic [7:0] haddr = 0, table_idx_q, tracks_per_surface_q, drive_sel_q;
  logic [7:0] mux_ports_q, uart_active_q;
  logic [1:0] htrans = 0, key_kind, active_row_q;
  logic [2:0] hsize = 3'h2;
  logic [3:0] key_code, param_sel_q, led_bright_q, head_select_code_q;
  logic [11:0] disp_value_q, step_period_nominal_q, step_period_end_q;
  logic [8:0] pass_limit_q;
  logic [31:0] hwdata = 0, hrdata, r;
  int bad_count = 0, checks = 0;
  assign hready = hreadyout;

  dtcm_operator u_dtcm_operator (.hclk, .key_stb, .key_kind, .key_code);
  dtcm_menu u_dtcm_menu (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite,
    .hsize, .hwdata, .hready, .hreadyout, .hresp, .hrdata, .diag_ok,
    .key_stb, .key_kind, .key_code, .test_start, .test_error,
    .test_pass_done, .active_row_q, .param_sel_q, .disp_value_q,
    .disp_blink_q, .disp_na_q, .led_bright_q, .head_select_code_q,
    .tracks_per_surface_q, .table_idx_q, .step_period_nominal_q,
    .step_period_start_q(), .step_period_end_q, .drive_sel_q,
    .humidity_q(), .mux_ports_q, .mux_on_q, .uart_active_q, .pass_limit_q,
    .test_run_q);

  // 20 MHz clock
  always #25 hclk = ~hclk;

  // --------------------------------------------------------------
  // shared tasks
  // --------------------------------------------------------------
  task automatic end_sim;
    if (bad_count == 0 && checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] x);
    checks++;
    if (g !== x) begin
      bad_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, g, x);
    end
  endtask
  // bounded wait for hready at a rising edge
  task automatic hw;
    int n;
    n = 0;
    do begin
      @(posedge hclk);
      n++;
    end while (hready !== 1'b1 && n < 20);
    if (hready !== 1'b1) begin
      bad_count++;
      end_sim;
    end
  endtask
  task automatic bus(input logic w, input logic [7:0] a,
                     input logic [31:0] wd, output logic [31:0] rd);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= 2'h2;
    hwrite <= w;
    hw;
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    hw;
    rd = hrdata;
    chk(hresp, 0);
  endtask
  task automatic k(input logic [1:0] t, input logic [3:0] c);
    u_dtcm_operator.press(t, c);
    @(posedge hclk);
    #1;
  endtask
  task automatic t3(input logic [11:0] v);
    k(C, v[11:8]);
    k(C, v[7:4]);
    k(C, v[3:0]);
  endtask
  task automatic e3(input logic [11:0] v);
    t3(v);
    k(E, 4'h0);
  endtask

  // --------------------------------------------------------------
  // main sequence
  // --------------------------------------------------------------
  initial begin
    repeat (16) @(posedge hclk);
    hresetn <= 1'b1;
    bus(0, DTCM_A_SETUP0, 0, r); chk(r, 32'h0102_0050);
    @(posedge hclk);
    diag_ok <= 1'b1;
    @(posedge hclk);
    diag_ok <= 1'b0;
    repeat (2) @(posedge hclk);
    #1 chk(param_sel_q, P_TABLE);
    chk(disp_blink_q, 1);
    chk(pass_limit_q, 9'h001);
    k(C, 4'h1); chk(disp_value_q, 12'h001);
    k(C, 4'h9); k(E, 4'h0); chk(table_idx_q, 8'h19);
    chk(param_sel_q, P_HEADS);
    e3(12'h004); chk(head_select_code_q, 4'h4);
    e3(12'h000); chk(tracks_per_surface_q, 8'h50);
    e3(12'h999); chk(step_period_nominal_q, 12'h999);
    e3(12'h001); e3(12'h000); chk(step_period_end_q, 12'h030);
    e3(12'h0AB); chk(drive_sel_q, 8'hAB);
    chk(disp_na_q, 1);
    k(E, 4'h0); e3(12'h0AA); chk(mux_ports_q, 8'hAA);
    chk(mux_on_q, 1);
    k(C, 4'hB); k(C, 4'hD); chk(led_bright_q, 4'hD);
    k(C, 4'hE); chk(led_bright_q, 4'h5);
    k(C, 4'hE); k(C, 4'hC); chk(led_bright_q, 4'hE);
    k(C, 4'hB); k(E, 4'h0); chk(param_sel_q, P_TABLE);
    chk(pass_limit_q, 9'h050);
    // a run with halt on must stop one edge after an error
    @(posedge hclk);
    test_start <= 1'b1;
    @(posedge hclk);
    test_start <= 1'b0;
    @(posedge hclk);
    #1 chk(test_run_q, 1);
    @(posedge hclk);
    test_error <= 1'b1;
    @(posedge hclk);
    test_error <= 1'b0;
    repeat (2) @(posedge hclk);
    #1 chk(test_run_q, 0);
    // single pass ends once the pass count reaches the track count
    @(posedge hclk);
    test_start <= 1'b1;
    @(posedge hclk);
    test_start <= 1'b0;
    test_pass_done <= 1'b1;
    repeat (79) @(posedge hclk);
    #1 chk(test_run_q, 1);
    @(posedge hclk);
    test_pass_done <= 1'b0;
    #1 chk(test_run_q, 0);
    t3(12'h001); k(R, 4'h2); chk(table_idx_q, 8'h01);
    chk(active_row_q, 2'h2);
    bus(1, DTCM_A_USTAGE, 32'h5A, r);
    bus(1, DTCM_A_SYS, 32'h1, r);
    k(R, 4'h1); k(C, 4'h2); chk(uart_active_q, 8'h00);
    k(E, 4'h0); chk(uart_active_q, 8'h5A);
    k(R, 4'h1); k(C, 4'h9); chk(disp_value_q, 12'h050);
    e3(12'h042);
    bus(0, DTCM_A_SETUP2, 0, r); chk(r, 32'hAA42_0030);
    bus(0, DTCM_A_SETUP1, 0, r); chk(r, 32'h0001_0999);
    bus(0, 8'h1C, 0, r); chk(r, 32'h0);
    end_sim;
  end
endmodule

`default_nettype wire

// ---- testbench/dtcm_operator.sv ----
// Purpose: front panel operator model pressing keypad keys
// Assumes: keys are one-cycle strobes taken at a rising hclk edge
// Notes:   released key lines show the inverse of the last code
`timescale 1ns/1ps
`default_nettype none

module dtcm_operator (
  input  wire logic  hclk,
  output logic       key_stb,
  output logic [1:0] key_kind,
  output logic [3:0] key_code
);
  // idle panel at time zero
  initial begin
    key_stb = 1'b0;
    key_kind = 2'h0;
    key_code = 4'h0;
  end

  // one strobe per press; lines then show the inverse so stale codes never match
  task automatic press(input logic [1:0] t, input logic [3:0] c);
    @(posedge hclk);
    key_stb <= 1'b1;
    key_kind <= t;
    key_code <= c;
    @(posedge hclk);
    key_stb <= 1'b0;
    key_kind <= ~t;
    key_code <= ~c;
  endtask
endmodule

`default_nettype wire
